// ### hdl/ctu_core.sv
// Charge-time unit control: registers, edge status, current-source gating
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ctu_core
  import ctu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [CTU_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [CTU_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire ctu_edges_s i_edges,
  input wire ctu_pwr_e i_power_mode,
  input wire logic i_comparator_trip,
  output logic o_source_on,
  output logic o_source_ground,
  output logic [1:0] o_current_range,
  output logic [5:0] o_current_trim,
  output logic o_delay_pulse_out
);
  logic [7:0] ctrlh_ff;
  logic [7:0] edge_ff;
  logic [7:0] current_ff;
  logic [CTU_ADDR_W-1:0] awaddr_ff;
  logic aw_got_ff;
  logic [31:0] wdata_ff;
  logic w_got_ff;
  logic [CTU_ADDR_W-1:0] nxt_waddr;
  logic [31:0] nxt_wdata;
  logic do_write;
  logic wr_ctrlh;
  logic wr_edge;
  logic wr_current;
  logic ev1_raw;
  logic ev2_raw;
  logic ev1;
  logic ev2;
  logic sleeping;
  logic idle_stop;
  logic nxt_source_on;
  logic trip_last_ff;

  // ---------------- AXI4-Lite write path ----------------
  // Address and data may arrive in either order; each is held until both
  assign nxt_waddr = aw_got_ff ? awaddr_ff : i_awaddr;
  assign nxt_wdata = w_got_ff ? wdata_ff : i_wdata;
  assign do_write = (aw_got_ff || (i_awvalid && o_awready)) &&
                    (w_got_ff || (i_wvalid && o_wready)) && !o_bvalid;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      o_bvalid <= 1'b0;
      o_bresp <= CTU_AXI_OKAY;
    end else begin
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        o_awready <= 1'b0;
        o_wready <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (wr_ctrlh || wr_edge || wr_current) ?
                   CTU_AXI_OKAY : CTU_AXI_SLVERR;
      end else begin
        if (i_awvalid && o_awready) begin
          aw_got_ff <= 1'b1;
          awaddr_ff <= i_awaddr;
        end
        if (i_wvalid && o_wready) begin
          w_got_ff <= 1'b1;
          wdata_ff <= i_wdata;
        end
        o_awready <= !o_bvalid && !aw_got_ff &&
                     !(i_awvalid && o_awready);
        o_wready <= !o_bvalid && !w_got_ff && !(i_wvalid && o_wready);
        if (o_bvalid && i_bready) begin
          o_bvalid <= 1'b0;
        end
      end
    end
  end

  // Byte lane 0 carries the 8-bit register
  assign wr_ctrlh = nxt_waddr == CTU_ADDR_CTRLH;
  assign wr_edge = nxt_waddr == CTU_ADDR_EDGE;
  assign wr_current = nxt_waddr == CTU_ADDR_CURRENT;

  // ---------------- Registers ----------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrlh_ff <= CTU_RESET_VAL;
    end else if (do_write && wr_ctrlh && i_wstrb_l0()) begin
      // Bits 6 and 0 hold no storage
      ctrlh_ff <= nxt_wdata[7:0] & CTU_H_WMASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      current_ff <= CTU_RESET_VAL;
    end else if (do_write && wr_current && i_wstrb_l0()) begin
      current_ff <= nxt_wdata[7:0];
    end
  end

  function automatic logic i_wstrb_l0();
    i_wstrb_l0 = i_wstrb[0];
  endfunction

  // ---------------- Edge detection ----------------
  ctu_edge_det u_edge1 (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_edges(i_edges),
    .i_source(edge_ff[CTU_L_E1_SRC +: 2]),
    .i_rising(edge_ff[CTU_L_E1_POL]),
    .o_event(ev1_raw)
  );

  ctu_edge_det u_edge2 (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_edges(i_edges),
    .i_source(edge_ff[CTU_L_E2_SRC +: 2]),
    .i_rising(edge_ff[CTU_L_E2_POL]),
    .o_event(ev2_raw)
  );

  // Edges count only when the unit runs and edges pass
  assign ev1 = ev1_raw && ctrlh_ff[CTU_H_ENABLE] &&
               ctrlh_ff[CTU_H_EDGE_PASS];
  assign ev2 = ev2_raw && ctrlh_ff[CTU_H_ENABLE] &&
               ctrlh_ff[CTU_H_EDGE_PASS] &&
               (!ctrlh_ff[CTU_H_ORDER] || edge_ff[CTU_L_E1_STAT]);

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      edge_ff <= CTU_RESET_VAL;
    end else begin
      if (do_write && wr_edge && i_wstrb[0]) begin
        edge_ff <= nxt_wdata[7:0];
      end
      if (ev1) begin
        edge_ff[CTU_L_E1_STAT] <= 1'b1;
      end
      if (ev2) begin
        edge_ff[CTU_L_E2_STAT] <= 1'b1;
      end
    end
  end

  // ---------------- Current source gating ----------------
  assign sleeping = i_power_mode == CTU_PWR_SLEEP ||
                    i_power_mode == CTU_PWR_DEEP;
  assign idle_stop = i_power_mode == CTU_PWR_IDLE &&
                     ctrlh_ff[CTU_H_STOP_IDLE];
  assign nxt_source_on = ctrlh_ff[CTU_H_ENABLE] &&
                         current_ff[CTU_I_RANGE +: 2] != CTU_RANGE_OFF &&
                         !ctrlh_ff[CTU_H_GROUND] && !sleeping &&
                         !idle_stop && edge_ff[CTU_L_E1_STAT] &&
                         !edge_ff[CTU_L_E2_STAT];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_source_on <= 1'b0;
      o_source_ground <= 1'b0;
      o_current_range <= CTU_RANGE_OFF;
      o_current_trim <= '0;
    end else begin
      o_source_on <= nxt_source_on;
      o_source_ground <= ctrlh_ff[CTU_H_GROUND];
      o_current_range <= current_ff[CTU_I_RANGE +: 2];
      o_current_trim <= current_ff[CTU_I_TRIM +: 6];
    end
  end

  // Trip is an on-chip comparator result, already synchronous
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      trip_last_ff <= 1'b0;
      o_delay_pulse_out <= 1'b0;
    end else begin
      trip_last_ff <= i_comparator_trip;
      o_delay_pulse_out <= ctrlh_ff[CTU_H_DELAY_GEN] &&
                           ctrlh_ff[CTU_H_ENABLE] &&
                           i_comparator_trip && !trip_last_ff;
    end
  end

  // ---------------- Read path ----------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= CTU_AXI_OKAY;
    end else begin
      if (i_arvalid && o_arready) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rresp <= CTU_AXI_OKAY;
        unique case (i_araddr)
          CTU_ADDR_CTRLH: o_rdata <= {24'h000000, ctrlh_ff};
          CTU_ADDR_EDGE: o_rdata <= {24'h000000, edge_ff};
          CTU_ADDR_CURRENT: o_rdata <= {24'h000000, current_ff};
          default: begin
            o_rdata <= '0;
            o_rresp <= CTU_AXI_SLVERR;
          end
        endcase
      end else begin
        o_arready <= !o_rvalid;
        if (o_rvalid && i_rready) begin
          o_rvalid <= 1'b0;
        end
      end
    end
  end

  // ---------------- Assertions ----------------
  a_sleep_source_off: assert property (@(posedge i_clk) disable iff (i_reset)
    sleeping |=> !o_source_on)
    else $error("source on during sleep");
  a_idle_stop_off: assert property (@(posedge i_clk) disable iff (i_reset)
    idle_stop |=> !o_source_on)
    else $error("source on during idle stop");
  a_reset_clears: assert property (@(posedge i_clk)
    i_reset |=> ctrlh_ff == 8'h00 && edge_ff == 8'h00 &&
    current_ff == 8'h00)
    else $error("registers not cleared by reset");
  a_reset_no_charge: assert property (@(posedge i_clk)
    i_reset |=> ##1 !o_source_on)
    else $error("charging survived reset");
  a_bit6_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    !ctrlh_ff[CTU_H_UNUSED] && !ctrlh_ff[CTU_H_RESV])
    else $error("unimplemented bit set");
  a_blocked_edges: assert property (@(posedge i_clk) disable iff (i_reset)
    !ctrlh_ff[CTU_H_EDGE_PASS] && !edge_ff[CTU_L_E1_STAT] &&
    !(do_write && wr_edge) |=> !edge_ff[CTU_L_E1_STAT])
    else $error("edge passed while blocked");
  a_edge_order: assert property (@(posedge i_clk) disable iff (i_reset)
    ctrlh_ff[CTU_H_ORDER] && !edge_ff[CTU_L_E1_STAT] &&
    !edge_ff[CTU_L_E2_STAT] && !(do_write && wr_edge)
    |=> !edge_ff[CTU_L_E2_STAT])
    else $error("edge 2 before edge 1");
  a_edge1_sets: assert property (@(posedge i_clk) disable iff (i_reset)
    ev1 |=> edge_ff[CTU_L_E1_STAT])
    else $error("edge 1 status missed");
  a_edge2_sets: assert property (@(posedge i_clk) disable iff (i_reset)
    ev2 |=> edge_ff[CTU_L_E2_STAT])
    else $error("edge 2 status missed");
  a_ground_blocks: assert property (@(posedge i_clk) disable iff (i_reset)
    ctrlh_ff[CTU_H_GROUND] |=> o_source_ground && !o_source_on)
    else $error("ground not applied");
  a_source_on_cause: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_source_on) |-> $past(edge_ff[CTU_L_E1_STAT]) &&
    $past(ctrlh_ff[CTU_H_ENABLE]))
    else $error("source on without cause");
  a_pulse_gated: assert property (@(posedge i_clk) disable iff (i_reset)
    o_delay_pulse_out |-> $past(ctrlh_ff[CTU_H_DELAY_GEN]))
    else $error("pulse without delay gen");
  a_pulse_trip: assert property (@(posedge i_clk) disable iff (i_reset)
    ctrlh_ff[CTU_H_DELAY_GEN] && ctrlh_ff[CTU_H_ENABLE] &&
    $rose(i_comparator_trip) |=> o_delay_pulse_out ##1
    !o_delay_pulse_out)
    else $error("trip pulse wrong");

  c_charge: cover property (@(posedge i_clk) $rose(o_source_on));
  c_both_edges: cover property (@(posedge i_clk)
    edge_ff[CTU_L_E1_STAT] ##[1:20] edge_ff[CTU_L_E2_STAT]);
  c_pulse: cover property (@(posedge i_clk) o_delay_pulse_out);
  c_bad_read: cover property (@(posedge i_clk)
    o_rvalid && o_rresp == CTU_AXI_SLVERR);
endmodule

// ### hdl/ctu_edge_det.sv
// One edge detector: source select, polarity, single-shot event pulse
`timescale 1ns/1ps
module ctu_edge_det
  import ctu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire ctu_edges_s i_edges,
  input wire logic [1:0] i_source,
  input wire logic i_rising,
  output logic o_event
);
  logic [3:0] src_vec;
  logic sel;
  logic last_ff;
  logic primed_ff;

  assign src_vec = {i_edges.pin1, i_edges.pin2, i_edges.cap1, i_edges.cap2};
  assign sel = src_vec[i_source];

  // Primed after one sample so leaving reset gives no false edge; a source switch still can
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      last_ff <= 1'b0;
      primed_ff <= 1'b0;
    end else begin
      last_ff <= sel;
      primed_ff <= 1'b1;
    end
  end

  // One pulse per transition of the chosen polarity
  assign o_event = primed_ff && (i_rising ? (sel && !last_ff)
                                          : (!sel && last_ff));
endmodule

// ### hdl/ctu_pkg.sv
// Package: register map, field positions and encodings of the charge-time unit
package ctu_pkg;
  // Printed offsets are not multiples of four: kept as indices
  localparam logic [11:0] CTU_IDX_CURRENT = 12'hfb1;
  localparam logic [11:0] CTU_IDX_EDGE = 12'hfb2;
  localparam logic [11:0] CTU_IDX_CTRLH = 12'hfb3;
  localparam int CTU_ADDR_W = 16;
  localparam logic [15:0] CTU_ADDR_CURRENT = 16'h3ec4;
  localparam logic [15:0] CTU_ADDR_EDGE = 16'h3ec8;
  localparam logic [15:0] CTU_ADDR_CTRLH = 16'h3ecc;
  localparam logic [7:0] CTU_RESET_VAL = 8'h00;
  // Control-high fields
  localparam int CTU_H_ENABLE = 7;
  localparam int CTU_H_UNUSED = 6;
  localparam int CTU_H_STOP_IDLE = 5;
  localparam int CTU_H_DELAY_GEN = 4;
  localparam int CTU_H_EDGE_PASS = 3;
  localparam int CTU_H_ORDER = 2;
  localparam int CTU_H_GROUND = 1;
  localparam int CTU_H_RESV = 0;
  localparam logic [7:0] CTU_H_WMASK = 8'hbe;
  // Edge config/status fields
  localparam int CTU_L_E2_POL = 7;
  localparam int CTU_L_E2_SRC = 5;
  localparam int CTU_L_E1_POL = 4;
  localparam int CTU_L_E1_SRC = 2;
  localparam int CTU_L_E2_STAT = 1;
  localparam int CTU_L_E1_STAT = 0;
  // Current control fields
  localparam int CTU_I_TRIM = 2;
  localparam int CTU_I_RANGE = 0;
  localparam logic [1:0] CTU_RANGE_OFF = 2'h0;
  // Edge source encodings
  typedef enum logic [1:0] {
    CTU_SRC_CAP2 = 2'b00,
    CTU_SRC_CAP1 = 2'b01,
    CTU_SRC_PIN2 = 2'b10,
    CTU_SRC_PIN1 = 2'b11
  } ctu_src_e;
  typedef enum logic [1:0] {
    CTU_PWR_RUN = 2'b00,
    CTU_PWR_IDLE = 2'b01,
    CTU_PWR_SLEEP = 2'b10,
    CTU_PWR_DEEP = 2'b11
  } ctu_pwr_e;
  // Raw edge sources, one bit each, indexed by source code
  typedef struct packed {
    logic pin1;
    logic pin2;
    logic cap1;
    logic cap2;
  } ctu_edges_s;
  typedef enum logic [1:0] {
    CTU_AXI_OKAY = 2'b00,
    CTU_AXI_SLVERR = 2'b10
  } ctu_resp_e;
endpackage

// ### sim/charge_time_edge_control_tb_top.sv
// Bench for the charge-time unit control block
`timescale 1ns/1ps
module charge_time_edge_control_tb_top
  import ctu_pkg::*;
();
  logic clk, rst, trip, src_on, gnd, pulse;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, range_o;
  logic [5:0] trim_o;
  ctu_edges_s edges;
  ctu_pwr_e pwr;
  int mismatches, n_tests;
  logic [15:0] addrs [3] = '{CTU_ADDR_CURRENT, CTU_ADDR_EDGE, CTU_ADDR_CTRLH};

  ctu_core u_dut (.i_clk(clk), .i_reset(rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_edges(edges), .i_power_mode(pwr),
    .i_comparator_trip(trip), .o_source_on(src_on),
    .o_source_ground(gnd), .o_current_range(range_o),
    .o_current_trim(trim_o), .o_delay_pulse_out(pulse));
  ctu_far_side u_far (.i_clk(clk), .o_edges(edges), .o_trip(trip));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    $display("[FAIL] t=%0t timeout got %h exp %h", $time, 1'b0, 1'b1);
    give_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] er = CTU_AXI_OKAY);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    input logic [1:0] er = CTU_AXI_OKAY);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        d = rdata;
        chk(32'(rresp), 32'(er));
        return;
      end
    end
    hang();
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, 32'(e));
  endtask
  // Source gating settles one cycle after status; three leaves margin
  task automatic on_chk(input logic e);
    repeat (3) @(posedge clk);
    chk(32'(src_on), 32'(e));
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    hang();
  end

  initial begin
    logic [31:0] d;
    logic [7:0] v;
    int cnt;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h1;
    pwr = CTU_PWR_RUN;
    mismatches = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(87));
    foreach (addrs[i]) rdc(addrs[i], CTU_RESET_VAL);
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'h7c : (i == 1) ? 8'h87 : 8'($urandom);
      wr(CTU_ADDR_CURRENT, v);
      rdc(CTU_ADDR_CURRENT, v);
      chk(32'(range_o), 32'(v[1:0]));
      chk(32'(trim_o), 32'(v[7:2]));
    end
    // Lane 0 strobe low: the write is answered but must not land
    wstrb <= 4'h0;
    wr(CTU_ADDR_CURRENT, ~v);
    rdc(CTU_ADDR_CURRENT, v);
    wstrb <= 4'h1;
    wr(CTU_ADDR_CTRLH, 8'hfe);
    rdc(CTU_ADDR_CTRLH, 8'hbe);
    chk(32'(gnd), 32'h1);
    wr(16'h3ed0, 8'h5a, CTU_AXI_SLVERR);
    rd(16'h3ed0, d, CTU_AXI_SLVERR);
    chk(d, 32'h0);
    wr(CTU_ADDR_CTRLH, 8'h88);
    for (int e = 0; e < 2; e++)
      for (int s = 0; s < 4; s++)
        for (int p = 0; p < 2; p++) begin
          v = e ? {p[0], s[1:0], 5'h0} : {3'h0, p[0], s[1:0], 2'h0};
          // Second write clears any status set by the mux switching
          repeat (2) wr(CTU_ADDR_EDGE, v);
          u_far.make_edge(2'(s ^ 1), p[0]);
          rd(CTU_ADDR_EDGE, d);
          chk(32'(d[e]), 32'h0);
          u_far.make_edge(s[1:0], p[0]);
          rd(CTU_ADDR_EDGE, d);
          chk(32'(d[e]), 32'h1);
        end
    wr(CTU_ADDR_CTRLH, 8'h8c);
    repeat (2) wr(CTU_ADDR_EDGE, 8'hdc);
    u_far.make_edge(2'h2, 1'b1);
    rdc(CTU_ADDR_EDGE, 8'hdc);
    u_far.make_edge(2'h3, 1'b1);
    u_far.make_edge(2'h2, 1'b1);
    rdc(CTU_ADDR_EDGE, 8'hdf);
    for (int h = 0; h < 2; h++) begin
      wr(CTU_ADDR_CTRLH, h ? 8'h08 : 8'h80);
      repeat (2) wr(CTU_ADDR_EDGE, 8'hdc);
      u_far.make_edge(2'h3, 1'b1);
      rdc(CTU_ADDR_EDGE, 8'hdc);
    end
    wr(CTU_ADDR_CURRENT, 8'h01);
    wr(CTU_ADDR_CTRLH, 8'h80);
    wr(CTU_ADDR_EDGE, 8'h01);
    on_chk(1'b1);
    wr(CTU_ADDR_EDGE, 8'h03);
    on_chk(1'b0);
    wr(CTU_ADDR_EDGE, 8'h01);
    wr(CTU_ADDR_CTRLH, 8'h82);
    on_chk(1'b0);
    wr(CTU_ADDR_CTRLH, 8'h80);
    wr(CTU_ADDR_CURRENT, 8'h00);
    on_chk(1'b0);
    wr(CTU_ADDR_CURRENT, 8'h03);
    for (int m = 0; m < 4; m++)
      for (int h = 0; h < 2; h++) begin
        wr(CTU_ADDR_CTRLH, h ? 8'ha0 : 8'h80);
        pwr <= ctu_pwr_e'(2'(m));
        on_chk(m == 0 || (m == 1 && h == 0));
        pwr <= CTU_PWR_RUN;
      end
    wr(CTU_ADDR_CTRLH, 8'h00);
    on_chk(1'b0);
    for (int g = 0; g < 2; g++) begin
      wr(CTU_ADDR_CTRLH, g ? 8'h80 : 8'h90);
      cnt = 0;
      fork
        u_far.trip_pulse();
        repeat (10) begin
          @(posedge clk);
          cnt += int'(pulse);
        end
      join
      chk(cnt, g ? 0 : 1);
    end
    wr(CTU_ADDR_EDGE, 8'h01);
    on_chk(1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(src_on), 32'h0);
    rst <= 1'b0;
    foreach (addrs[i]) rdc(addrs[i], CTU_RESET_VAL);
    wr(CTU_ADDR_CTRLH, 8'h02);
    rdc(CTU_ADDR_CTRLH, 8'h02);
    chk(32'(gnd), 32'h1);
    wr(CTU_ADDR_CTRLH, 8'h00);
    rdc(CTU_ADDR_CTRLH, 8'h00);
    chk(32'(gnd), 32'h0);
    give_verdict();
  end
endmodule

// ### sim/ctu_far_side.sv
// Far-side model: edge source lines and comparator trip
`timescale 1ns/1ps
module ctu_far_side
  import ctu_pkg::*;
(
  input wire logic i_clk,
  output ctu_edges_s o_edges,
  output logic o_trip
);
  initial begin
    o_edges = '0;
    o_trip = 1'b0;
  end
  // Opposite level first, so a real edge follows; each level held
  // three cycles because the detector samples on the clock
  task automatic make_edge(input logic [1:0] src, input logic rising);
    logic [3:0] v;
    v = o_edges;
    v[src] = ~rising;
    @(posedge i_clk);
    o_edges <= v;
    repeat (3) @(posedge i_clk);
    v[src] = rising;
    o_edges <= v;
    repeat (3) @(posedge i_clk);
  endtask
  // Comparator stays tripped several cycles, as a real node would
  task automatic trip_pulse();
    @(posedge i_clk);
    o_trip <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_trip <= 1'b0;
  endtask
endmodule
